// File: inc/arp_defines.svh
// Constants of the auto-incrementing RAM pointer
`ifndef ARP_DEFINES_SVH
`define ARP_DEFINES_SVH

// Register addresses on the CPU external-data bus
`define ARP_PTR_HI_ADDR 16'h7FE3
`define ARP_PTR_LO_ADDR 16'h7FE4
`define ARP_DATA_ADDR 16'h7FE5

// Pointer reset value and step
`define ARP_PTR_RST 16'h0000
`define ARP_PTR_STEP 16'h0001

// Field positions of the pointer bytes
`define ARP_HI_MSB 15
`define ARP_HI_LSB 8
`define ARP_LO_MSB 7
`define ARP_LO_LSB 0

// Read value for an address this block does not own
`define ARP_UNMAPPED_DATA 8'h00

// Internal RAM window reachable by the pointer
`define ARP_RAM_BASE 16'h0000
`define ARP_RAM_BYTES 8192

// Fast transfer budget: two CPU cycles
`define ARP_FAST_NS 333
`define ARP_CLK_MHZ 100
`define ARP_FAST_CYC ((`ARP_FAST_NS * `ARP_CLK_MHZ) / 1000)
`define ARP_CNT_W 8

// Data path FIFO
`define ARP_FIFO_DEPTH 4

`endif

// File: inc/arp_pkg.sv
// Types shared by the auto-incrementing RAM pointer
package arp_pkg;

   typedef logic [15:0] arp_addr_t;

   // One RAM write waiting in the data path FIFO
   typedef struct packed
   {
      logic [15:0] addr;
      logic [7:0] data;
   } arp_wr_s;

   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_WR_PUSH,
      ST_RD_DRAIN,
      ST_RD_DATA
   } arp_state_e;

endpackage

// File: src/arp_fifo.sv
// Small valid/ready FIFO for queued RAM writes
`timescale 1ns/1ps
`default_nettype none
module arp_fifo
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_idx_ff;
   logic [AW-1:0] rd_idx_ff;
   logic [CW-1:0] cnt_ff;
   wire logic push;
   wire logic pop;

   assign in_ready = (cnt_ff != FULL_CNT);
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem[rd_idx_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_idx_ff] <= in_data;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_idx_ff <= '0;
         rd_idx_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (push)
            wr_idx_ff <= (wr_idx_ff == LAST_IDX) ? '0 : wr_idx_ff + 1'b1;
         if (pop)
            rd_idx_ff <= (rd_idx_ff == LAST_IDX) ? '0 : rd_idx_ff + 1'b1;
         if (push && !pop)
            cnt_ff <= cnt_ff + 1'b1;
         else if (pop && !push)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: src/arp_ram.sv
// Internal program/data RAM window behind the pointer
`timescale 1ns/1ps
`default_nettype none
`include "arp_defines.svh"
module arp_ram
#(
   parameter logic [15:0] BASE = `ARP_RAM_BASE,
   parameter int BYTES = `ARP_RAM_BYTES
)
(
   // Clock
   input wire logic clk,
   // Access port
   input wire logic we,
   input wire logic re,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_ff
);
   localparam int IW = $clog2(BYTES);
   localparam logic [16:0] TOP = 17'(BASE) + 17'(BYTES);

   logic [7:0] mem [BYTES];
   wire logic [15:0] offs;
   wire logic in_range;
   wire logic [IW-1:0] idx;

   // Outside internal RAM: writes dropped, reads give zero
   assign offs = addr - BASE;
   assign in_range = (addr >= BASE) && (17'(addr) < TOP);
   assign idx = offs[IW-1:0];

   always_ff @(posedge clk)
   begin
      if (we && in_range)
         mem[idx] <= wdata;
   end

   always_ff @(posedge clk)
   begin
      if (re)
         rdata_ff <= in_range ? mem[idx] : `ARP_UNMAPPED_DATA;
   end
endmodule
`default_nettype wire

// File: src/arp_autopointer.sv
// Auto-incrementing RAM pointer with data port and fast transfer
`timescale 1ns/1ps
`default_nettype none
`include "arp_defines.svh"
module arp_autopointer
#(
   parameter int FIFO_DEPTH = `ARP_FIFO_DEPTH,
   parameter logic [15:0] RAM_BASE = `ARP_RAM_BASE,
   parameter int RAM_BYTES = `ARP_RAM_BYTES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // CPU external-data access
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   output logic cpu_ack_ff,
   output logic [7:0] cpu_rdata_ff,
   // Fast transfer
   input wire logic fast_bulk_enable,
   input wire logic [7:0] ext_din,
   output logic [7:0] ext_dout_ff,
   output logic ext_oe_n_ff,
   output logic fast_late_ff,
   // RAM port taken by another master
   input wire logic ram_hold
);
   localparam int WR_W = $bits(arp_pkg::arp_wr_s);
   localparam logic [`ARP_CNT_W-1:0] FAST_CYC =
      `ARP_CNT_W'(`ARP_FAST_CYC);

   ////////////////////////////////////////////////////////////////////
   // State
   arp_pkg::arp_state_e state_ff;
   arp_pkg::arp_state_e nxt_state;
   arp_pkg::arp_addr_t ptr_ff;
   logic req_fast_ff;
   logic [7:0] req_wdata_ff;
   logic [`ARP_CNT_W-1:0] fast_cnt_ff;
   logic [7:0] ext_s1_ff;
   logic [7:0] ext_s2_ff;
   logic [7:0] ext_s3_ff;

   ////////////////////////////////////////////////////////////////////
   // Address decode
   wire logic hit_hi;
   wire logic hit_lo;
   wire logic hit_data;
   wire logic take;
   wire logic take_hi_wr;
   wire logic take_lo_wr;
   wire logic take_hi_rd;
   wire logic take_lo_rd;
   wire logic take_data_wr;
   wire logic take_data_rd;
   wire logic take_other;
   wire logic take_fast;

   assign hit_hi = (cpu_addr == `ARP_PTR_HI_ADDR);
   assign hit_lo = (cpu_addr == `ARP_PTR_LO_ADDR);
   assign hit_data = (cpu_addr == `ARP_DATA_ADDR);
   assign take = cpu_req && (state_ff == arp_pkg::ST_IDLE);
   // Pointer bytes are served whenever the sequencer is in ST_IDLE, FIFO busy or not
   assign take_hi_wr = take && hit_hi && cpu_we;
   assign take_lo_wr = take && hit_lo && cpu_we;
   assign take_hi_rd = take && hit_hi && !cpu_we;
   assign take_lo_rd = take && hit_lo && !cpu_we;
   assign take_data_wr = take && hit_data && cpu_we;
   assign take_data_rd = take && hit_data && !cpu_we;
   assign take_other = take && !hit_hi && !hit_lo && !hit_data;
   assign take_fast = take && hit_data && fast_bulk_enable;

   ////////////////////////////////////////////////////////////////////
   // External data bus synchroniser
   wire logic ext_stable;

   // Byte counts once the second and third stages agree
   assign ext_stable = (ext_s2_ff == ext_s3_ff);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ext_s1_ff <= 8'h00;
         ext_s2_ff <= 8'h00;
         ext_s3_ff <= 8'h00;
      end
      else
      begin
         ext_s1_ff <= ext_din;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write path through the FIFO
   arp_pkg::arp_wr_s push_entry;
   arp_pkg::arp_wr_s pop_entry;
   wire logic push_valid;
   wire logic push_ready;
   wire logic push_done;
   wire logic pop_valid;
   wire logic pop_ready;
   wire logic [WR_W-1:0] pop_bits;

   // Fast write takes the byte on the external bus
   assign push_valid = (state_ff == arp_pkg::ST_WR_PUSH) &&
      (!req_fast_ff || ext_stable);
   assign push_entry.addr = ptr_ff;
   assign push_entry.data = req_fast_ff ? ext_s3_ff : req_wdata_ff;
   assign push_done = push_valid && push_ready;
   assign pop_ready = !ram_hold;
   assign pop_entry = arp_pkg::arp_wr_s'(pop_bits);

   arp_fifo
   #(
      .WIDTH(WR_W),
      .DEPTH(FIFO_DEPTH)
   )
   u_fifo
   (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_entry),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_bits)
   );

   ////////////////////////////////////////////////////////////////////
   // RAM access
   wire logic ram_we;
   wire logic ram_re;
   wire logic [15:0] ram_addr;
   wire logic [7:0] ram_rdata;

   // Reads wait for queued writes so data stays in order
   assign ram_we = pop_valid && !ram_hold;
   assign ram_re = (state_ff == arp_pkg::ST_RD_DRAIN) &&
      !pop_valid && !ram_hold;
   assign ram_addr = ram_we ? pop_entry.addr : ptr_ff;

   arp_ram
   #(
      .BASE(RAM_BASE),
      .BYTES(RAM_BYTES)
   )
   u_ram
   (
      .clk(clk),
      .we(ram_we),
      .re(ram_re),
      .addr(ram_addr),
      .wdata(pop_entry.data),
      .rdata_ff(ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////
   // Pointer
   wire logic ptr_step;
   wire arp_pkg::arp_addr_t ptr_inc;
   arp_pkg::arp_addr_t nxt_ptr;

   assign ptr_step = push_done || ram_re;
   assign ptr_inc = ptr_ff + `ARP_PTR_STEP;

   always_comb
   begin
      nxt_ptr = ptr_ff;
      if (take_hi_wr)
         nxt_ptr[`ARP_HI_MSB:`ARP_HI_LSB] = cpu_wdata;
      else if (take_lo_wr)
         nxt_ptr[`ARP_LO_MSB:`ARP_LO_LSB] = cpu_wdata;
      else if (ptr_step)
         nxt_ptr = ptr_inc;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ptr_ff <= `ARP_PTR_RST;
      else
         ptr_ff <= nxt_ptr;
   end

   ////////////////////////////////////////////////////////////////////
   // Request sequencer
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         arp_pkg::ST_IDLE:
         begin
            if (take_data_wr)
               nxt_state = arp_pkg::ST_WR_PUSH;
            else if (take_data_rd)
               nxt_state = arp_pkg::ST_RD_DRAIN;
         end
         arp_pkg::ST_WR_PUSH:
         begin
            if (push_done)
               nxt_state = arp_pkg::ST_IDLE;
         end
         arp_pkg::ST_RD_DRAIN:
         begin
            if (ram_re)
               nxt_state = arp_pkg::ST_RD_DATA;
         end
         arp_pkg::ST_RD_DATA:
            nxt_state = arp_pkg::ST_IDLE;
         default:
            nxt_state = arp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         state_ff <= arp_pkg::ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         req_fast_ff <= 1'b0;
         req_wdata_ff <= 8'h00;
      end
      else if (take)
      begin
         req_fast_ff <= take_fast;
         req_wdata_ff <= cpu_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // CPU answer
   wire logic ack_now;
   wire logic rd_done;
   logic [7:0] nxt_rdata;

   assign rd_done = (state_ff == arp_pkg::ST_RD_DATA);
   assign ack_now = take_hi_wr || take_lo_wr || take_hi_rd ||
      take_lo_rd || take_other || push_done || rd_done;

   // Pointer reads show the address of the next access
   always_comb
   begin
      nxt_rdata = cpu_rdata_ff;
      if (take_hi_rd)
         nxt_rdata = ptr_ff[`ARP_HI_MSB:`ARP_HI_LSB];
      else if (take_lo_rd)
         nxt_rdata = ptr_ff[`ARP_LO_MSB:`ARP_LO_LSB];
      else if (take_other)
         nxt_rdata = `ARP_UNMAPPED_DATA;
      else if (rd_done)
         nxt_rdata = ram_rdata;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cpu_ack_ff <= 1'b0;
         cpu_rdata_ff <= 8'h00;
      end
      else
      begin
         cpu_ack_ff <= ack_now;
         cpu_rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Fast read drive onto the external bus
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ext_dout_ff <= 8'h00;
         ext_oe_n_ff <= 1'b1;
      end
      else if (rd_done && req_fast_ff)
      begin
         ext_dout_ff <= ram_rdata;
         ext_oe_n_ff <= 1'b0;
      end
      else if (take)
         ext_oe_n_ff <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // Fast transfer time budget
   wire logic fast_busy;
   wire logic over_budget;

   assign fast_busy = req_fast_ff && (state_ff != arp_pkg::ST_IDLE);
   assign over_budget = fast_busy && (fast_cnt_ff >= FAST_CYC);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         fast_cnt_ff <= '0;
      else if (take)
         fast_cnt_ff <= '0;
      else if (fast_busy && !over_budget)
         fast_cnt_ff <= fast_cnt_ff + 1'b1;
   end

   // Sticky until the next fast request is taken
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         fast_late_ff <= 1'b0;
      else if (over_budget)
         fast_late_ff <= 1'b1;
      else if (take_fast)
         fast_late_ff <= 1'b0;
   end
endmodule
`default_nettype wire

// File: sim/arp_autopointer_props.sv
// Checker for the auto-incrementing RAM pointer ports
`timescale 1ns/1ps
`default_nettype none
`include "arp_defines.svh"
module arp_autopointer_props
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // CPU access
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic cpu_ack_ff,
   input wire logic [7:0] cpu_rdata_ff,
   // Fast transfer
   input wire logic fast_bulk_enable,
   input wire logic [7:0] ext_dout_ff,
   input wire logic ext_oe_n_ff
);
   logic pend_ff, wr_ff, dat_ff, reg_ff, fast_ff;
   logic [15:0] ptr_ff;
   logic [7:0] exp_ff;
   wire take = cpu_req && (!pend_ff || cpu_ack_ff);
   wire is_dat = cpu_addr == `ARP_DATA_ADDR;
   wire is_hi = cpu_addr == `ARP_PTR_HI_ADDR;
   wire is_lo = cpu_addr == `ARP_PTR_LO_ADDR;
   // Shadow of the pointer and of the request in flight
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pend_ff <= 1'b0;
         ptr_ff <= `ARP_PTR_RST;
      end
      else if (take)
      begin
         pend_ff <= 1'b1;
         if (is_dat)
            ptr_ff <= ptr_ff + 16'h0001;
         else if (cpu_we && is_hi)
            ptr_ff[15:8] <= cpu_wdata;
         else if (cpu_we && is_lo)
            ptr_ff[7:0] <= cpu_wdata;
      end
      else if (cpu_ack_ff)
         pend_ff <= 1'b0;
   end
   always_ff @(posedge clk)
   begin
      if (take)
      begin
         wr_ff <= cpu_we;
         dat_ff <= is_dat;
         reg_ff <= !is_dat;
         fast_ff <= fast_bulk_enable;
         exp_ff <= is_hi ? ptr_ff[15:8] : is_lo ? ptr_ff[7:0] : 8'h00;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_ack_has_req: assert property (cpu_ack_ff |-> pend_ff)
      else $error("answer without request");
   chk_reg_ack_next: assert property (take && !is_dat |=> cpu_ack_ff)
      else $error("register access late");
   chk_reg_rdata: assert property (cpu_ack_ff && reg_ff && !wr_ff
      |-> cpu_rdata_ff == exp_ff) else $error("pointer read wrong");
   chk_wr_not_early: assert property (take && is_dat && cpu_we
      |=> !cpu_ack_ff) else $error("data write answered early");
   chk_rd_not_early: assert property (take && is_dat && !cpu_we
      |=> !cpu_ack_ff [*2]) else $error("data read answered early");
   chk_oe_fast_only: assert property ($fell(ext_oe_n_ff)
      |-> cpu_ack_ff && dat_ff && !wr_ff && fast_ff)
      else $error("bus driven outside fast read");
   chk_oe_release: assert property (take && !ext_oe_n_ff
      |=> ext_oe_n_ff) else $error("bus not released");
   chk_dout_match: assert property ($fell(ext_oe_n_ff)
      |-> ext_dout_ff == cpu_rdata_ff) else $error("bus byte wrong");
   chk_fast_budget: assert property (take && is_dat && fast_bulk_enable
      |-> ##[2:33] cpu_ack_ff) else $error("fast access too slow");
   chk_ack_bound: assert property (take |-> ##[1:60] cpu_ack_ff)
      else $error("no answer");
   cover property (take && is_dat && cpu_we);
   cover property ($fell(ext_oe_n_ff));
   cover property (cpu_ack_ff && reg_ff && !wr_ff);
endmodule
bind arp_autopointer arp_autopointer_props i_arp_autopointer_props
(
   .clk, .rst_n, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ack_ff,
   .cpu_rdata_ff, .fast_bulk_enable, .ext_dout_ff, .ext_oe_n_ff
);
`default_nettype wire

// File: sim/arp_ext_model.sv
// External bus device model for fast transfers
`timescale 1ns/1ps
`default_nettype none
module arp_ext_model
(
   // Clock
   input wire logic clk,
   // Byte the device offers
   input wire logic [7:0] src_byte,
   // Bus pins
   output logic [7:0] ext_din,
   input wire logic [7:0] ext_dout_ff,
   input wire logic ext_oe_n_ff,
   // Last byte taken from the bus
   output logic [7:0] sink_byte
);
   assign ext_din = src_byte;
   always_ff @(posedge clk)
   begin
      if (!ext_oe_n_ff)
      begin
         sink_byte <= ext_dout_ff;
      end
   end
endmodule
`default_nettype wire

// File: sim/test_arp_autopointer.sv
// Testbench for the auto-incrementing RAM pointer
`timescale 1ns/1ps
`default_nettype none
`include "arp_defines.svh"
module test_arp_autopointer;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cpu_req = 1'b0;
   logic cpu_we = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [7:0] cpu_wdata = 8'h00;
   logic fast_bulk_enable = 1'b0;
   logic ram_hold = 1'b0;
   logic [7:0] src_byte = 8'h00;
   wire logic [7:0] ext_din, ext_dout_ff, cpu_rdata_ff, sink_byte;
   wire logic cpu_ack_ff, ext_oe_n_ff, fast_late_ff;
   logic [7:0] rd;
   logic [7:0] pat [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
   logic [7:0] fb [2] = '{8'h5A, 8'hA5};
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   arp_autopointer i_arp_autopointer (.clk, .rst_n, .cpu_req, .cpu_we,
      .cpu_addr, .cpu_wdata, .cpu_ack_ff, .cpu_rdata_ff, .fast_bulk_enable,
      .ext_din, .ext_dout_ff, .ext_oe_n_ff, .fast_late_ff, .ram_hold);
   arp_ext_model i_arp_ext_model (.clk, .src_byte, .ext_din, .ext_dout_ff,
      .ext_oe_n_ff, .sink_byte);
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic acc(input logic we, input logic [15:0] a,
      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      cpu_req = 1'b1;
      cpu_we = we;
      cpu_addr = a;
      cpu_wdata = d;
      @(posedge clk);
      #1;
      cpu_req = 1'b0;
      while (cpu_ack_ff !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp({7'h00, cpu_ack_ff}, 8'h01);
      rd = cpu_rdata_ff;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      cmp(rd, exp);
   endtask
   task automatic setp(input logic [15:0] p);
      acc(1'b1, `ARP_PTR_HI_ADDR, p[15:8]);
      acc(1'b1, `ARP_PTR_LO_ADDR, p[7:0]);
   endtask
   task automatic chkp(input logic [15:0] p);
      rdc(`ARP_PTR_HI_ADDR, p[15:8]);
      rdc(`ARP_PTR_LO_ADDR, p[7:0]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chkp(16'h0000);
      setp(16'h12FE);
      chkp(16'h12FE);
      // Queue fills while the RAM is held elsewhere
      ram_hold = 1'b1;
      for (int i = 0; i < 4; i++)
         acc(1'b1, `ARP_DATA_ADDR, pat[i]);
      fork
         begin
            repeat (15) @(posedge clk);
            #1;
            ram_hold = 1'b0;
         end
      join_none
      acc(1'b1, `ARP_DATA_ADDR, pat[4]);
      chkp(16'h1303);
      setp(16'h12FE);
      for (int i = 0; i < 5; i++)
         rdc(`ARP_DATA_ADDR, pat[i]);
      rdc(16'h7FE6, 8'h00);
      rdc(16'h7FE2, 8'h00);
      setp(16'h3000);
      acc(1'b1, `ARP_DATA_ADDR, 8'hAA);
      setp(16'h3000);
      rdc(`ARP_DATA_ADDR, 8'h00);
      setp(16'hFFFF);
      acc(1'b0, `ARP_DATA_ADDR, 8'h00);
      chkp(16'h0000);
      // Fast writes take the bus byte, not the write data
      fast_bulk_enable = 1'b1;
      setp(16'h0100);
      for (int i = 0; i < 2; i++)
      begin
         src_byte = fb[i];
         repeat (4) @(posedge clk);
         acc(1'b1, `ARP_DATA_ADDR, 8'h00);
      end
      setp(16'h0100);
      for (int i = 0; i < 2; i++)
      begin
         rdc(`ARP_DATA_ADDR, fb[i]);
         @(posedge clk);
         #1;
         cmp(sink_byte, fb[i]);
      end
      chkp(16'h0102);
      cmp({7'h00, fast_late_ff}, 8'h00);
      fast_bulk_enable = 1'b0;
      setp(16'h0100);
      rdc(`ARP_DATA_ADDR, 8'h5A);
      @(posedge clk);
      #1;
      cmp(sink_byte, 8'hA5);
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chkp(16'h0000);
      complete_run();
   end
endmodule
`default_nettype wire
